// file: src/gps_sequencer.sv
`timescale 1ns/1ps

// Small first-word-fall-through buffer with valid and ready on both sides.
module gps_fifo #(
    parameter int W = 12,
    parameter int DEPTH = 16
) (
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic [W-1:0] in_data,
    input wire logic in_valid,
    output logic in_ready,
    output logic [W-1:0] out_data,
    output logic out_valid,
    input wire logic out_ready
);
    localparam int AW = $clog2(DEPTH);

    // The pointers wrap naturally only for a power-of-two depth.
    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
        $error("gps_fifo depth must be a power of two of at least 2.");
    end

    logic [W-1:0] store [DEPTH];  // Buffer storage.
    logic [AW-1:0] wr_ptr;  // Next slot to fill.
    logic [AW-1:0] rd_ptr;  // Oldest slot.
    logic [AW:0] count;  // Items held.
    logic push;
    logic pop;

    assign in_ready = (count != (AW + 1)'(DEPTH));
    assign out_valid = (count != '0);
    assign out_data = store[rd_ptr];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    // Storage writes.
    always_ff @(posedge mclk) begin
        if (push) begin
            store[wr_ptr] <= in_data;
        end
    end

    // Pointers and fill count.
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
        end else begin
            wr_ptr <= wr_ptr + AW'(push);
            rd_ptr <= rd_ptr + AW'(pop);
            count <= count + (AW + 1)'(push) - (AW + 1)'(pop);
        end
    end
endmodule // gps_fifo

// Field sequencer and projection accumulator on the image clock.
module gps_sequencer #(
    parameter int FIFO_DEPTH = gps_pkg::GPS_FIFO_DEPTH
) (
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic soft_reset,
    input wire logic run_set,
    input wire gps_pkg::gps_mode_t mode,
    input wire gps_pkg::gps_rd_ctl_t rd_ctl,
    input wire logic [7:0] pixel_in,
    input wire logic vertical_window_n,
    input wire logic horizontal_window_n,
    input wire logic field_id_in,
    input wire logic rd_req,
    input wire logic rd_vert,
    input wire logic [10:0] rd_addr,
    output logic run_bit,
    output logic busy_n,
    output logic first_field_id_out,
    output logic overrun,
    output logic [15:0] rd_data,
    output logic rd_valid
);
    import gps_pkg::*;

    // The buffer depth is fixed by the timing budget of the accumulators.
    if (FIFO_DEPTH < 2) begin : g_bad_fifo
        $error("gps_sequencer needs a buffer of at least two words.");
    end

    // Sequencer states.
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_CLEAR,
        ST_ARMED,
        ST_FIELD1,
        ST_GAP,
        ST_FIELD2,
        ST_WAIT
    } gps_state_t;

    gps_state_t state;  // Field sequencer state.
    logic rst_any;  // Hardware or software reset.
    logic [7:0] pix_s1, pix_s2;  // Pixel synchroniser.
    logic [2:0] ctl_s1, ctl_s2;  // Strobe and field id synchroniser.
    logic vw_q, hw_q;  // Strobes one cycle older, for edges.
    logic vw_fall, vw_rise, line_end, in_window;
    logic fresh;  // No run since the last reset.
    logic split_second;  // Split store: next field goes high.
    logic [8:0] clr_idx;  // Memory clear walker.
    logic fid_cap;  // Field id caught at the window start.
    logic fid_pend;  // Caught id waits one cycle.
    gps_item_t push_item, pop_item;
    logic push_valid, fifo_ready, pop_valid, drain_ready, pop;
    logic [GPS_SUM_W-1:0] vert_mem [GPS_WORDS];  // Column sums.
    logic [GPS_SUM_W-1:0] horiz_mem [GPS_WORDS];  // Line sums.
    logic [8:0] col;  // Column of the next pixel.
    logic [8:0] line;  // Line within the field.
    logic [GPS_SUM_W-1:0] line_sum;  // Running line sum.
    logic first_line;  // Column sums restart on this line.
    logic drain_done;  // Last field marker left the buffer.
    logic [8:0] h_wr_addr;
    logic [GPS_SUM_W-1:0] rd_word;

    // Software reset acts as a full reset except for the pin synchronisers and strobe copies, and so beats a run request.
    assign rst_any = sys_rst || soft_reset;

    // Two flip-flops in front of every pin input.
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            pix_s1 <= 8'h00;
            pix_s2 <= 8'h00;
            ctl_s1 <= 3'h7;
            ctl_s2 <= 3'h7;
        end else begin
            pix_s1 <= pixel_in;
            pix_s2 <= pix_s1;
            ctl_s1 <= {vertical_window_n, horizontal_window_n, field_id_in};
            ctl_s2 <= ctl_s1;
        end
    end

    // Delayed strobe copies for edge detection.
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            vw_q <= 1'b1;
            hw_q <= 1'b1;
        end else begin
            vw_q <= ctl_s2[2];
            hw_q <= ctl_s2[1];
        end
    end

    // A field is exactly one low period of the vertical strobe.
    assign vw_fall = vw_q && !ctl_s2[2];
    assign vw_rise = !vw_q && ctl_s2[2];
    // Line ends rely on the source keeping a gap of line_gap_width.
    assign line_end = !hw_q && ctl_s2[1] && !ctl_s2[2];
    assign in_window = !ctl_s2[2] && !ctl_s2[1];

    // Field sequencer, run bit and busy output.
    always_ff @(posedge mclk) begin
        if (rst_any) begin
            state <= ST_IDLE;
            run_bit <= 1'b0;
            busy_n <= 1'b1;
            fresh <= 1'b1;
            split_second <= 1'b0;
            clr_idx <= 9'h000;
        end else begin
            if (run_set) begin
                run_bit <= 1'b1;
            end
            case (state)
                ST_IDLE: begin
                    if (run_bit) begin
                        // A first run after reset clears both memories.
                        state <= fresh ? ST_CLEAR : ST_ARMED;
                    end
                end
                ST_CLEAR: begin
                    clr_idx <= clr_idx + 9'h001;
                    if (clr_idx == GPS_LAST_WORD) begin
                        fresh <= 1'b0;
                        state <= ST_ARMED;
                    end
                end
                ST_ARMED: begin
                    if (vw_fall) begin
                        busy_n <= 1'b0;
                        state <= ST_FIELD1;
                    end
                end
                ST_FIELD1: begin
                    if (vw_rise) begin
                        // Two-field frames keep busy through the gap.
                        state <= (mode.scan && !mode.single_field) ? ST_GAP : ST_WAIT;
                    end
                end
                ST_GAP: begin
                    // The field gap is field_gap_width cycles or more.
                    if (vw_fall) begin
                        state <= ST_FIELD2;
                    end
                end
                ST_FIELD2: begin
                    if (vw_rise) begin
                        state <= ST_WAIT;
                    end
                end
                ST_WAIT: begin
                    // Ends only once the last sums are in memory.
                    if (drain_done) begin
                        run_bit <= 1'b0;
                        busy_n <= 1'b1;
                        state <= ST_IDLE;
                        if (mode.scan && mode.single_field) begin
                            split_second <= 1'b1;
                        end
                    end
                end
                default: begin
                    state <= ST_IDLE;
                end
            endcase
        end
    end

    // First-field id: caught at the window start, shown one clock later.
    always_ff @(posedge mclk) begin
        if (rst_any) begin
            first_field_id_out <= 1'b1;
            fid_cap <= 1'b1;
            fid_pend <= 1'b0;
        end else begin
            fid_pend <= (state == ST_ARMED) && vw_fall;
            if ((state == ST_ARMED) && vw_fall) begin
                fid_cap <= mode.scan ? ctl_s2[0] : 1'b1;
            end
            if (fid_pend) begin
                first_field_id_out <= fid_cap;
            end
        end
    end

    // Build the buffered item for the current cycle.
    always_comb begin
        push_item.pix = pix_s2;
        push_item.kind = GPS_PIXEL;
        push_item.hi_half = (state == ST_FIELD2) ||
                            (mode.scan && mode.single_field && split_second);
        push_item.last = (state == ST_FIELD2) || !mode.scan || mode.single_field;
        push_valid = 1'b0;
        if ((state == ST_FIELD1) || (state == ST_FIELD2)) begin
            if (vw_rise) begin
                push_item.kind = GPS_FIELD_END;
                push_valid = 1'b1;
            end else if (line_end) begin
                push_item.kind = GPS_LINE_END;
                push_valid = 1'b1;
            end else if (in_window) begin
                push_valid = 1'b1;
            end
        end
    end

    // Sticky flag for items lost to a full buffer.
    always_ff @(posedge mclk) begin
        if (rst_any) begin
            overrun <= 1'b0;
        end else if (push_valid && !fifo_ready) begin
            overrun <= 1'b1;
        end
    end

    gps_fifo #(
        .W($bits(gps_item_t)),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .mclk(mclk),
        .sys_rst(rst_any),
        .in_data(push_item),
        .in_valid(push_valid),
        .in_ready(fifo_ready),
        .out_data(pop_item),
        .out_valid(pop_valid),
        .out_ready(drain_ready)
    );

    // The accumulators stall while the memories are being cleared.
    assign drain_ready = (state != ST_CLEAR);
    assign pop = pop_valid && drain_ready;
    assign h_wr_addr = pop_item.hi_half ? (GPS_HALF_BASE | {1'b0, line[7:0]}) : line;

    // Column, line and running line sum counters.
    always_ff @(posedge mclk) begin
        if (rst_any) begin
            col <= 9'h000;
            line <= 9'h000;
            line_sum <= '0;
            first_line <= 1'b1;
            drain_done <= 1'b0;
        end else begin
            drain_done <= pop && (pop_item.kind == GPS_FIELD_END) && pop_item.last;
            if (pop) begin
                case (pop_item.kind)
                    GPS_PIXEL: begin
                        col <= col + 9'h001;
                        line_sum <= line_sum + GPS_SUM_W'(pop_item.pix);
                    end
                    GPS_LINE_END: begin
                        col <= 9'h000;
                        line <= line + 9'h001;
                        line_sum <= '0;
                        first_line <= 1'b0;
                    end
                    default: begin
                        col <= 9'h000;
                        line <= 9'h000;
                        line_sum <= '0;
                        // Only the end of a run restarts column sums.
                        first_line <= pop_item.last ? 1'b1 : first_line;
                    end
                endcase
            end
        end
    end

    // Column sums: overwrite on a run's first line, else add.
    always_ff @(posedge mclk) begin
        if (state == ST_CLEAR) begin
            vert_mem[clr_idx] <= '0;
        end else if (pop && (pop_item.kind == GPS_PIXEL)) begin
            vert_mem[col] <= (first_line ? '0 : vert_mem[col]) + GPS_SUM_W'(pop_item.pix);
        end
    end

    // Line sums are stored whole at each line end.
    always_ff @(posedge mclk) begin
        if (state == ST_CLEAR) begin
            horiz_mem[clr_idx] <= '0;
        end else if (pop && (pop_item.kind == GPS_LINE_END)) begin
            horiz_mem[h_wr_addr] <= line_sum;
        end
    end

    // Host word index to stored horizontal word.
    function automatic logic [8:0] gps_hmap(input logic [8:0] w, input logic scan,
                                            input gps_rd_ctl_t c, input logic ff);
        if (!scan || c.read_order) begin
            return w;
        end
        return {w[0] ^ c.start_parity_select ^ ff, w[8:1]};
    endfunction

    // Reads are valid once busy is high again.
    assign rd_word = rd_vert ? vert_mem[rd_addr[10:GPS_RD_WORD_LSB]] :
        horiz_mem[gps_hmap(rd_addr[10:GPS_RD_WORD_LSB], mode.scan, rd_ctl,
                           first_field_id_out)];

    // Registered read answer; the lowest address bit plays no part.
    always_ff @(posedge mclk) begin
        if (rst_any) begin
            rd_data <= 16'h0000;
            rd_valid <= 1'b0;
        end else begin
            rd_valid <= rd_req;
            if (rd_req) begin
                rd_data <= rd_addr[GPS_RD_HI_BIT] ? {14'h0000, rd_word[17:16]} :
                           rd_word[15:0];
            end
        end
    end

    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst_any);

    AST_BUSY_START: assert property ((state == ST_ARMED) && vw_fall |=> !busy_n)
        else $error("busy did not fall at window start.");
    AST_DONE_CLEARS: assert property (drain_done && (state == ST_WAIT) |=> run_bit == 1'b0 && busy_n)
        else $error("run end did not clear run bit and busy.");
    AST_TWO_FIELD: assert property ((state == ST_FIELD1) && vw_rise && mode.scan
        && !mode.single_field |=> (state == ST_GAP) && !busy_n)
        else $error("two-field run left busy early.");
    AST_SINGLE_END: assert property ((state == ST_FIELD1) && vw_rise && mode.single_field
        |=> state == ST_WAIT)
        else $error("single field run did not end after one field.");
    AST_FID_DELAY: assert property ((state == ST_ARMED) && vw_fall && mode.scan
        |-> ##2 first_field_id_out == $past(ctl_s2[0], 2))
        else $error("field id not shown two cycles after window start.");
    AST_FID_NONINT: assert property ((state == ST_ARMED) && vw_fall && !mode.scan
        |-> ##2 first_field_id_out)
        else $error("field id not high in progressive mode.");
    AST_FID_HOLD: assert property ((state == ST_FIELD2) |-> $stable(first_field_id_out))
        else $error("field id changed in the second field.");
    AST_CLEAR_END: assert property ((state == ST_CLEAR) && (clr_idx == GPS_LAST_WORD)
        |=> (state == ST_ARMED) && !fresh)
        else $error("memory clear did not finish at the last word.");
    AST_HALF_WRITE: assert property (pop && (pop_item.kind == GPS_LINE_END) && pop_item.hi_half
        |-> h_wr_addr[8])
        else $error("second field line sum written to low half.");
    AST_SOFT_RESET: assert property (disable iff (sys_rst) soft_reset |=> !run_bit && busy_n)
        else $error("soft reset did not win over run.");
endmodule // gps_sequencer

// file: src/gps_pkg.sv
package gps_pkg;
    // Result memory shape: one word per line or column sum.
    localparam int GPS_WORDS = 512;
    localparam int GPS_ADDR_W = 9;
    localparam int GPS_SUM_W = 18;
    localparam int GPS_PIX_W = 8;
    // Second-field horizontal sums start at this word.
    localparam logic [8:0] GPS_HALF_BASE = 9'h100;
    localparam logic [8:0] GPS_LAST_WORD = 9'h1FF;
    // Host read address fields: word index, high-part select, ignored lane bit.
    localparam int GPS_RD_ADDR_W = 11;
    localparam int GPS_RD_WORD_LSB = 2;
    localparam int GPS_RD_HI_BIT = 1;
    localparam int GPS_RD_DATA_W = 16;
    // Least gap widths the image source keeps, in image clock cycles.
    localparam int GPS_LINE_GAP_WIDTH = 3;
    localparam int GPS_FIELD_GAP_WIDTH = 3;
    // Depth of the pixel buffer between the pins and the accumulators.
    localparam int GPS_FIFO_DEPTH = 16;

    // Kind of item that travels through the pixel buffer.
    typedef enum logic [1:0] {
        GPS_PIXEL,
        GPS_LINE_END,
        GPS_FIELD_END
    } gps_kind_t;

    // One buffered item: a pixel or a line or field boundary marker.
    typedef struct packed {
        logic [7:0] pix;
        gps_kind_t kind;
        logic hi_half;
        logic last;
    } gps_item_t;

    // Processing mode selects.
    typedef struct packed {
        logic scan;
        logic single_field;
    } gps_mode_t;

    // Horizontal read-out mapping selects.
    typedef struct packed {
        logic read_order;
        logic start_parity_select;
    } gps_rd_ctl_t;
endpackage

// file: sim/gps_video_src.sv
`timescale 1ns/1ps

// Behavioural image source that drives the window strobes, the pixels and the field id.
// No vertical sync is ever produced, so fields are framed by the window alone.
module gps_video_src (
    input wire logic mclk,
    output logic [7:0] pixel_in,
    output logic vertical_window_n,
    output logic horizontal_window_n,
    output logic field_id_in
);
    import gps_pkg::*;
    logic [7:0] noise; // Churning value shown while no pixel is valid.
    logic [7:0] pix_d; // Pixel currently presented inside a line.
    logic pix_on; // High while a pixel is inside both windows.

    // Outside the window the bus changes every cycle, so stale data never looks valid.
    assign pixel_in = pix_on ? pix_d : noise;

    // Idle levels at time zero.
    initial begin
        noise = 8'h00;
        pix_d = 8'h00;
        pix_on = 1'b0;
        vertical_window_n = 1'b1;
        horizontal_window_n = 1'b1;
        field_id_in = 1'b1;
    end

    // The noise pattern moves on at each falling edge.
    always @(negedge mclk) begin
        noise <= noise + 8'h5b;
    end

    // Sends one field of lines x npix pixels; pixel value depends on line and column.
    task automatic send_field(input int lines, input int npix, input logic fid,
                              input logic [7:0] base);
        field_id_in = fid;
        @(negedge mclk);
        vertical_window_n = 1'b0;
        repeat (GPS_LINE_GAP_WIDTH) @(negedge mclk);
        for (int l = 0; l < lines; l++) begin
            for (int c = 0; c < npix; c++) begin
                horizontal_window_n = 1'b0;
                pix_d = base + 8'(l * 13) + 8'(c * 7);
                pix_on = 1'b1;
                @(negedge mclk);
            end
            horizontal_window_n = 1'b1;
            pix_on = 1'b0;
            repeat (GPS_LINE_GAP_WIDTH) @(negedge mclk);
        end
        vertical_window_n = 1'b1;
        repeat (GPS_FIELD_GAP_WIDTH) @(negedge mclk);
    endtask
endmodule // gps_video_src

// file: sim/testbench.sv
`timescale 1ns/1ps

// Self-checking bench for the field sequencer, its buffer and its result read-out.
module testbench;
    import gps_pkg::*;
    logic mclk;
    logic sys_rst;
    logic soft_reset;
    logic run_set;
    gps_mode_t mode;
    gps_rd_ctl_t rd_ctl;
    logic [7:0] pixel_in;
    logic vertical_window_n;
    logic horizontal_window_n;
    logic field_id_in;
    logic rd_req;
    logic rd_vert;
    logic [10:0] rd_addr;
    logic run_bit;
    logic busy_n;
    logic first_field_id_out;
    logic overrun;
    logic [15:0] rd_data;
    logic rd_valid;
    logic [17:0] hexp [GPS_WORDS]; // Expected line sums.
    logic [17:0] vexp [GPS_WORDS]; // Expected column sums.
    logic [17:0] val;
    int errors;
    int n_tests;
    int cyc;
    int nl, np;

    gps_sequencer gps_sequencer_inst (.mclk(mclk), .sys_rst(sys_rst), .soft_reset(soft_reset),
        .run_set(run_set), .mode(mode), .rd_ctl(rd_ctl), .pixel_in(pixel_in),
        .vertical_window_n(vertical_window_n), .horizontal_window_n(horizontal_window_n),
        .field_id_in(field_id_in), .rd_req(rd_req), .rd_vert(rd_vert), .rd_addr(rd_addr),
        .run_bit(run_bit), .busy_n(busy_n), .first_field_id_out(first_field_id_out),
        .overrun(overrun), .rd_data(rd_data), .rd_valid(rd_valid));
    gps_video_src gps_video_src_inst (.mclk(mclk), .pixel_in(pixel_in),
        .vertical_window_n(vertical_window_n), .horizontal_window_n(horizontal_window_n),
        .field_id_in(field_id_in));

    // Free-running 250 MHz clock.
    initial begin
        mclk = 1'b0;
        forever #2 mclk = ~mclk;
    end

    // A hang is cut short after a fixed number of cycles.
    always @(posedge mclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            errors = errors + 1;
            report_and_stop();
        end
    end

    // Compares one value and reports a mismatch.
    task automatic check(input string what, input logic [17:0] seen, input logic [17:0] exp);
        n_tests = n_tests + 1;
        if (seen !== exp) begin
            errors = errors + 1;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // Prints the verdict and ends the run.
    task automatic report_and_stop();
        if (errors == 0 && n_tests > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // Expected pixel value, worked out independently of the source model.
    function automatic logic [7:0] pv(input logic [7:0] b, input int l, input int c);
        return b + 8'(l * 13) + 8'(c * 7);
    endfunction

    // Zeroes the expected memories, as a run from reset clears the real ones.
    task automatic clr_exp();
        for (int i = 0; i < GPS_WORDS; i++) begin
            hexp[i] = '0;
            vexp[i] = '0;
        end
    endtask

    // Holds the hardware reset for six cycles.
    task automatic do_reset();
        sys_rst = 1'b1;
        repeat (6) @(negedge mclk);
        sys_rst = 1'b0;
        clr_exp();
    endtask

    // Pulses the run bit, then leaves room for the memory clear before any window.
    task automatic start_run(input gps_mode_t m);
        mode = m;
        run_set = 1'b1;
        @(negedge mclk);
        run_set = 1'b0;
        repeat (520) @(negedge mclk);
        check("run_bit_armed", run_bit, 1);
        check("busy_before_window", busy_n, 1);
    endtask

    // Waits, bounded, for the run to end before the host touches results.
    task automatic wait_idle();
        for (int i = 0; i < 300 && busy_n !== 1'b1; i++) begin
            @(negedge mclk);
        end
    endtask

    // Reads one 18-bit result as low and high parts; the lane bit is random.
    task automatic rd(input logic v, input logic [8:0] w, output logic [17:0] r);
        logic [15:0] lo;
        for (int h = 0; h < 2; h++) begin
            rd_req = 1'b1;
            rd_vert = v;
            rd_addr = {w, h[0], 1'($urandom)};
            @(negedge mclk);
            rd_req = 1'b0;
            for (int i = 0; i < 3 && rd_valid !== 1'b1; i++) begin
                @(negedge mclk);
            end
            check("rd_valid", rd_valid, 1);
            if (h == 0) begin
                lo = rd_data;
            end else begin
                r = {rd_data[1:0], lo};
            end
            @(negedge mclk);
        end
    endtask

    // Reads a run of words and compares them with the expected memories.
    task automatic chk_mem(input logic v, input int first, input int cnt);
        for (int i = first; i < first + cnt; i++) begin
            rd(v, 9'(i), val);
            check(v ? "col_sum" : "line_sum", val, v ? vexp[i] : hexp[i]);
        end
    endtask

    // Sends one field and records the sums it should leave behind.
    task automatic field(input logic fid, input int hb, input bit addv);
        logic [7:0] b;
        logic [17:0] s;
        b = 8'($urandom);
        for (int l = 0; l < nl; l++) begin
            s = '0;
            for (int c = 0; c < np; c++) s += {10'h0, pv(b, l, c)};
            hexp[hb + l] = s;
        end
        for (int c = 0; c < np; c++) begin
            s = addv ? vexp[c] : '0;
            for (int l = 0; l < nl; l++) s += {10'h0, pv(b, l, c)};
            vexp[c] = s;
        end
        gps_video_src_inst.send_field(nl, np, fid, b);
    endtask

    // Main sequence.
    initial begin
        void'($urandom(32'h0634));
        sys_rst = 1'b1;
        soft_reset = 1'b0;
        run_set = 1'b0;
        mode = '0;
        rd_ctl = 2'b10;
        rd_req = 1'b0;
        rd_vert = 1'b0;
        rd_addr = '0;
        errors = 0;
        n_tests = 0;
        nl = 2 + int'($urandom % 4);
        np = 2 + int'($urandom % 5);
        do_reset();
        check("ffid_after_reset", first_field_id_out, 1);
        check("busy_after_reset", busy_n, 1);
        // Progressive: one frame, field id held high; the buffer must lose nothing.
        start_run(2'b00);
        field(1'b0, 0, 0);
        check("busy_in_frame", busy_n, 0);
        wait_idle();
        check("busy_end", busy_n, 1);
        check("run_bit_end", run_bit, 0);
        check("ffid_progressive", first_field_id_out, 1);
        check("overrun_frame", overrun, 0);
        chk_mem(0, 0, nl + 1);
        chk_mem(1, 0, np + 1);
        // Two-field frame: busy across the gap, split line sums, summed columns.
        do_reset();
        start_run(2'b10);
        field(1'b0, 0, 0);
        check("busy_in_gap", busy_n, 0);
        field(1'b1, 256, 1);
        wait_idle();
        check("busy_frame_end", busy_n, 1);
        check("ffid_held", first_field_id_out, 0);
        check("overrun_two_field", overrun, 0);
        chk_mem(0, 0, nl);
        chk_mem(0, 256, nl);
        chk_mem(1, 0, np);
        // Coordinate-order reads interleave the two fields by parity.
        for (int s = 0; s < 2; s++) begin
            rd_ctl = {1'b0, s[0]};
            for (int w = 0; w < 2 * nl; w++) begin
                rd(0, 9'(w), val);
                check("coord_read", val, hexp[{w[0] ^ s[0], 8'(w >> 1)}]);
            end
        end
        rd_ctl = 2'b10;
        // Single field: stops after field one; unarmed field two leaves no trace.
        do_reset();
        start_run(2'b11);
        field(1'b1, 0, 0);
        wait_idle();
        check("single_busy_end", busy_n, 1);
        check("single_run_end", run_bit, 0);
        check("ffid_single", first_field_id_out, 1);
        gps_video_src_inst.send_field(nl, np, 1'b0, 8'h3c);
        check("unarmed_field_idle", busy_n, 1);
        chk_mem(0, 0, nl);
        chk_mem(0, 256, 1);
        // Split store: a rerun without reset goes to the upper half.
        start_run(2'b11);
        field(1'b0, 256, 0);
        wait_idle();
        chk_mem(0, 0, nl);
        chk_mem(0, 256, nl);
        chk_mem(1, 0, np);
        check("ffid_rerun", first_field_id_out, 0);
        // Soft reset together with run: reset wins, then a fresh run clears memory.
        soft_reset = 1'b1;
        run_set = 1'b1;
        @(negedge mclk);
        soft_reset = 1'b0;
        run_set = 1'b0;
        @(negedge mclk);
        check("soft_rst_run_bit", run_bit, 0);
        check("soft_rst_ffid", first_field_id_out, 1);
        clr_exp();
        start_run(2'b00);
        field(1'b0, 0, 0);
        wait_idle();
        chk_mem(0, 0, nl + 1);
        chk_mem(0, 256, 1);
        check("overrun_clear", overrun, 0);
        report_and_stop();
    end
endmodule // testbench
